/* File: design/vphy_params.svh */
// register offsets, field positions, reset values and timing counts
// assumes a 40 MHz system clock and word-indexed plain register port
`ifndef VPHY_PARAMS_SVH
`define VPHY_PARAMS_SVH
`define OFS_BASIC_CTRL   5'h00
`define OFS_BASIC_STAT   5'h01
`define OFS_ADV          5'h04
`define OFS_PARTNER      5'h05
`define OFS_EXPANSION    5'h06
`define OFS_CHIP_RESET_CONTROL_REG    5'h10
`define OFS_MANUAL_FC    5'h11
`define OFS_MODE_CTL     5'h12
`define BIT_SOFT_RST     15
`define BIT_SPEED        13
`define BIT_AN_EN        12
`define BIT_AN_RESTART   9
`define BIT_DUPLEX       8
`define BIT_AN_DONE      5
`define BIT_PAGE_RX      1
`define BIT_PARTNER_ABLE 0
`define BIT_SYM_PAUSE    10
`define BIT_ASYM_PAUSE   11
`define BIT_RC_VPHY      3
`define BIT_RC_DIGITAL   10
`define BIT_FC_MANUAL    0
`define RST_BASIC_CTRL   16'h3100
`define RST_ADV          16'h05e1
`define STAT_CONST       16'h7809
`define RESET_TIME_NS    102000
`define CLK_PERIOD_NS    25
`define RESET_CYCLES     (`RESET_TIME_NS / `CLK_PERIOD_NS)
`endif

/* File: design/vphy_pkg.sv */
// types shared by the emulated management register bank
// assumes the constants header is included by users
package vphy_pkg;
  typedef enum logic [3:0] {
    NEG_IDLE   = 4'h1,
    NEG_DONE   = 4'h2,
    NEG_PAGE   = 4'h4,
    NEG_RESULT = 4'h8
  } neg_state_t;
endpackage : vphy_pkg

/* File: design/emulated_phy_autoneg_regs.sv */
// emulated single-port phy register bank with emulated negotiation
// assumes plain register port on ref_clk; pins and straps from outside
`timescale 1ns/100ps
`include "vphy_params.svh"

module emulated_phy_autoneg_regs #(
  parameter int RESET_CYCLES = `RESET_CYCLES
) (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic [4:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  input  wire logic        mii_mgmt_access,
  output logic      [15:0] reg_rdata,
  input  wire logic        duplex_pin,
  input  wire logic        duplex_pol_strap,
  input  wire logic        speed_strap,
  input  wire logic        mac_mode,
  input  wire logic        eeprom_reload,
  output logic             port_speed_100,
  output logic             port_full_duplex,
  output logic             port_tx_pause,
  output logic             port_rx_pause
);

  // ----------------------------------------
  // elaboration check
  // ----------------------------------------
  if (RESET_CYCLES < 2 || RESET_CYCLES > 65535) begin : g_bad_reset_cycles
    $error("RESET_CYCLES out of range");
  end

  // ----------------------------------------
  // duplex pin synchroniser
  // ----------------------------------------
  logic [2:0] sync_dup;
  logic       duplex_s;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      sync_dup <= 3'h0;
      duplex_s <= 1'b0;
    end else begin
      sync_dup <= {sync_dup[1:0], duplex_pin};
      if (sync_dup[1] == sync_dup[2]) begin
        duplex_s <= sync_dup[2];
      end
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [15:0] basic_ctrl;
  logic [15:0] adv;
  logic [15:0] partner;
  logic        an_done;
  logic        page_rx;
  logic        partner_able;
  logic        rc_vphy;
  logic        rc_digital;
  logic [3:0]  manual_fc;
  logic [15:0] rst_count;
  logic        basic_rst_pend;
  logic        res_speed;
  logic        res_duplex;
  logic        res_tx_pause;
  logic        res_rx_pause;
  vphy_pkg::neg_state_t neg_state;

  logic mii_blocked;
  logic wr_basic;
  logic wr_adv;
  logic wr_rc;
  logic soft_reset;
  logic restart;

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  function automatic logic reg_hit(input logic [4:0] a, input logic [4:0] want, input logic blocked);
    return (a == want) && !blocked;
  endfunction : reg_hit

  assign mii_blocked = mac_mode && mii_mgmt_access;
  assign wr_basic    = reg_write && reg_hit(reg_addr, `OFS_BASIC_CTRL, mii_blocked);
  assign wr_adv      = reg_write && reg_hit(reg_addr, `OFS_ADV, mii_blocked);
  assign wr_rc       = reg_write && reg_addr == `OFS_CHIP_RESET_CONTROL_REG;
  // reload brings the register set back like a soft reset
  assign soft_reset = (wr_rc && (reg_wdata[`BIT_RC_VPHY] || reg_wdata[`BIT_RC_DIGITAL])) ||
                      (wr_basic && reg_wdata[`BIT_SOFT_RST]) || eeprom_reload;
  assign restart    = soft_reset || eeprom_reload || (wr_basic && reg_wdata[`BIT_AN_RESTART]);

  // ----------------------------------------
  // partner abilities
  // ----------------------------------------
  function automatic logic [15:0] partner_abilities(input logic dup_eq, input logic spd,
                                                    input logic [15:0] a);
    logic [15:0] p;
    p = 16'h0001;
    if (spd) begin
      p[8] = dup_eq;
      p[7] = 1'b1;
    end
    p[6] = dup_eq;
    p[5] = 1'b1;
    p[`BIT_SYM_PAUSE]  = a[`BIT_SYM_PAUSE];
    p[`BIT_ASYM_PAUSE] = a[`BIT_ASYM_PAUSE];
    return p;
  endfunction : partner_abilities

  // best common mode as {speed_100, full_duplex}
  function automatic logic [1:0] best_common_mode(input logic [3:0] c);
    logic [1:0] m;
    m = 2'b00;
    if (c[3]) begin
      m = 2'b11;
    end else if (c[2]) begin
      m = 2'b10;
    end else if (c[1]) begin
      m = 2'b01;
    end
    return m;
  endfunction : best_common_mode

  // pause result as {tx, rx} from {asym, sym}
  function automatic logic [1:0] pause_result(input logic [1:0] p);
    logic [1:0] r;
    r = 2'b00;
    r[1] = p[1] || p[0];
    r[0] = p[0];
    return r;
  endfunction : pause_result

  logic [15:0] lp;
  logic [3:0]  common;

  assign lp     = partner_abilities(duplex_s == duplex_pol_strap, speed_strap, adv);
  assign common = adv[8:5] & lp[8:5];

  // ----------------------------------------
  // basic control
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      basic_ctrl <= `RST_BASIC_CTRL;
    end else if (soft_reset) begin
      basic_ctrl                <= `RST_BASIC_CTRL;
      basic_ctrl[`BIT_SOFT_RST] <= wr_basic && reg_wdata[`BIT_SOFT_RST];
    end else if (wr_basic) begin
      basic_ctrl <= {1'b0, reg_wdata[14:10], 1'b0, reg_wdata[8:0]};
    end else if (basic_rst_pend && neg_state == vphy_pkg::NEG_IDLE) begin
      basic_ctrl[`BIT_SOFT_RST] <= 1'b0;
    end
  end

  // soft reset bit stays up until negotiation settles
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      basic_rst_pend <= 1'b0;
    end else if (soft_reset) begin
      basic_rst_pend <= wr_basic && reg_wdata[`BIT_SOFT_RST];
    end else if (basic_rst_pend && neg_state == vphy_pkg::NEG_IDLE) begin
      basic_rst_pend <= 1'b0;
    end
  end

  // ----------------------------------------
  // advertisement
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      adv <= `RST_ADV;
    end else if (soft_reset) begin
      adv <= `RST_ADV;
    end else if (wr_adv) begin
      adv <= {4'h0, reg_wdata[11:10], 1'b0, reg_wdata[8:5], 5'h01};
    end
  end

  // ----------------------------------------
  // reset control and its self-clear timer
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rc_vphy    <= 1'b0;
      rc_digital <= 1'b0;
      rst_count  <= 16'h0;
    end else if (soft_reset) begin
      rc_vphy    <= wr_rc && reg_wdata[`BIT_RC_VPHY];
      rc_digital <= wr_rc && reg_wdata[`BIT_RC_DIGITAL];
      rst_count  <= RESET_CYCLES[15:0];
    end else if (rst_count != 16'h0) begin
      rst_count <= rst_count - 16'h1;
    end else begin
      rc_vphy    <= 1'b0;
      rc_digital <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      manual_fc <= 4'h0;
    end else if (reg_write && reg_addr == `OFS_MANUAL_FC) begin
      manual_fc <= reg_wdata[3:0];
    end
  end

  // ----------------------------------------
  // emulated negotiation
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      neg_state    <= vphy_pkg::NEG_DONE;
      an_done      <= 1'b0;
      page_rx      <= 1'b0;
      partner_able <= 1'b0;
      partner      <= 16'h0;
      res_speed    <= 1'b0;
      res_duplex   <= 1'b0;
      res_tx_pause <= 1'b0;
      res_rx_pause <= 1'b0;
    end else begin
      if (reg_read && reg_hit(reg_addr, `OFS_EXPANSION, mii_blocked)) begin
        page_rx <= 1'b0;
      end
      if (restart) begin
        neg_state    <= vphy_pkg::NEG_DONE;
        an_done      <= 1'b0;
        page_rx      <= 1'b0;
        partner_able <= 1'b0;
      end else begin
        unique case (neg_state)
          vphy_pkg::NEG_IDLE: begin
            neg_state <= vphy_pkg::NEG_IDLE;
          end
          vphy_pkg::NEG_DONE: begin
            if (basic_ctrl[`BIT_AN_EN]) begin
              an_done   <= 1'b1;
              neg_state <= vphy_pkg::NEG_PAGE;
            end
          end
          vphy_pkg::NEG_PAGE: begin
            page_rx   <= 1'b1;
            neg_state <= vphy_pkg::NEG_RESULT;
          end
          vphy_pkg::NEG_RESULT: begin
            neg_state <= vphy_pkg::NEG_IDLE;
            if (common != 4'h0) begin
              partner_able <= 1'b1;
              partner      <= lp;
              {res_speed, res_duplex}      <= best_common_mode(common);
              {res_tx_pause, res_rx_pause} <= pause_result(adv[`BIT_ASYM_PAUSE:`BIT_SYM_PAUSE]);
            end else begin
              partner_able <= 1'b0;
              partner      <= speed_strap ? 16'h0081 : 16'h0021;
              res_speed    <= speed_strap;
              res_duplex   <= 1'b0;
              res_tx_pause <= 1'b0;
              res_rx_pause <= 1'b0;
            end
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // port configuration
  // ----------------------------------------
  logic an_on;
  logic manual_sel;
  assign an_on      = basic_ctrl[`BIT_AN_EN];
  assign manual_sel = !an_on || manual_fc[`BIT_FC_MANUAL];

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      port_speed_100   <= 1'b0;
      port_full_duplex <= 1'b0;
      port_tx_pause    <= 1'b0;
      port_rx_pause    <= 1'b0;
    end else begin
      if (mac_mode) begin
        port_speed_100   <= speed_strap;
        port_full_duplex <= an_on ? (duplex_s == duplex_pol_strap) : basic_ctrl[`BIT_DUPLEX];
      end else if (an_on) begin
        port_speed_100   <= res_speed;
        port_full_duplex <= res_duplex;
      end else begin
        port_speed_100   <= basic_ctrl[`BIT_SPEED];
        port_full_duplex <= basic_ctrl[`BIT_DUPLEX];
      end
      port_tx_pause <= manual_sel ? manual_fc[2] : res_tx_pause;
      port_rx_pause <= manual_sel ? manual_fc[1] : res_rx_pause;
    end
  end

  // ----------------------------------------
  // read data
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      reg_rdata <= 16'h0;
    end else if (reg_read) begin
      if (mii_blocked) begin
        reg_rdata <= 16'hffff;
      end else begin
        unique case (reg_addr)
          `OFS_BASIC_CTRL: reg_rdata <= basic_ctrl;
          `OFS_BASIC_STAT: reg_rdata <= `STAT_CONST | {10'h0, an_done, 5'h0};
          `OFS_ADV:        reg_rdata <= adv;
          `OFS_PARTNER:    reg_rdata <= partner;
          `OFS_EXPANSION:  reg_rdata <= {14'h0, page_rx, partner_able};
          `OFS_CHIP_RESET_CONTROL_REG:  reg_rdata <= {5'h0, rc_digital, 6'h0, rc_vphy, 3'h0};
          `OFS_MANUAL_FC:  reg_rdata <= {11'h0, port_full_duplex, port_tx_pause, port_rx_pause, 1'b0,
                                         manual_fc[`BIT_FC_MANUAL]};
          default:         reg_rdata <= 16'h0;
        endcase
      end
    end else begin
      reg_rdata <= 16'h0;
    end
  end

endmodule : emulated_phy_autoneg_regs

/* File: tb/vphy_chk.sv */
// assertion checker for the emulated phy register bank
// assumes the ports of emulated_phy_autoneg_regs; bound at the foot
`timescale 1ns/100ps
`include "vphy_params.svh"
module vphy_chk #(
  parameter int RESET_CYCLES = `RESET_CYCLES
) (
  input wire logic        ref_clk,
  input wire logic        rst_n,
  input wire logic [4:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_write,
  input wire logic        reg_read,
  input wire logic        mii_mgmt_access,
  input wire logic [15:0] reg_rdata,
  input wire logic        duplex_pin,
  input wire logic        duplex_pol_strap,
  input wire logic        mac_mode,
  input wire logic        eeprom_reload,
  input wire logic        port_speed_100,
  input wire logic        port_full_duplex
);
  // ----------
  // control shadow and reset age
  // ----------
  logic        blk, an_s, spd_s, dup_s, ctl_wr;
  logic [15:0] age;
  assign blk = mac_mode & mii_mgmt_access;
  assign ctl_wr = reg_write && !blk && reg_addr == `OFS_BASIC_CTRL;
  always_ff @(posedge ref_clk) begin
    if (!rst_n || eeprom_reload || (ctl_wr && reg_wdata[15]) ||
        (reg_write && reg_addr == `OFS_CHIP_RESET_CONTROL_REG && (reg_wdata[3] || reg_wdata[10])))
      {an_s, spd_s, dup_s} <= 3'b111;
    else if (ctl_wr)
      {an_s, spd_s, dup_s} <= {reg_wdata[12], reg_wdata[13], reg_wdata[8]};
  end
  always_ff @(posedge ref_clk) begin
    if (!rst_n)
      age <= 16'hffff;
    else if (reg_write && reg_addr == `OFS_CHIP_RESET_CONTROL_REG && reg_wdata[3])
      age <= 16'h0000;
    else if (age != 16'hffff)
      age <= age + 16'h0001;
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  chk_idle_rdata_zero: assert property (!reg_read |=> reg_rdata == 16'h0000)
    else $error("read data not zero");
  chk_mii_read_blocked: assert property (blk && reg_read |=> reg_rdata == 16'hffff)
    else $error("blocked read not all ones");
  chk_no_extra_ability: assert property (reg_read && !blk && reg_addr inside {`OFS_ADV, `OFS_PARTNER}
    |=> (reg_rdata & 16'ha200) == 16'h0000) else $error("next page, fault or t4 shown");
  chk_status_no_extra: assert property (reg_read && !blk && reg_addr == `OFS_BASIC_STAT
    |=> (reg_rdata & 16'h8010) == 16'h0000) else $error("status shows t4 or fault");
  chk_forced_speed_duplex: assert property ((!mac_mode && !an_s && $stable({spd_s, dup_s}))[*4]
    |-> port_speed_100 == spd_s && port_full_duplex == dup_s) else $error("forced mode wrong");
  chk_mac_pin_duplex: assert property ((mac_mode && an_s && $stable(duplex_pin)
    && $stable(duplex_pol_strap))[*8] |-> port_full_duplex == (duplex_pin == duplex_pol_strap))
    else $error("mac duplex not from pin");
  chk_mac_forced_duplex: assert property ((mac_mode && !an_s && $stable(dup_s))[*4]
    |-> port_full_duplex == dup_s) else $error("mac duplex not from control");
  chk_reset_bit_clears: assert property (reg_read && !blk && reg_addr == `OFS_CHIP_RESET_CONTROL_REG
    && age > RESET_CYCLES + 4 |=> !reg_rdata[3]) else $error("reset bit did not clear");
endmodule : vphy_chk
bind emulated_phy_autoneg_regs vphy_chk #(.RESET_CYCLES(RESET_CYCLES)) u_vphy_chk (.ref_clk(ref_clk),
  .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
  .mii_mgmt_access(mii_mgmt_access), .reg_rdata(reg_rdata), .duplex_pin(duplex_pin),
  .duplex_pol_strap(duplex_pol_strap), .mac_mode(mac_mode), .eeprom_reload(eeprom_reload),
  .port_speed_100(port_speed_100), .port_full_duplex(port_full_duplex));

/* File: tb/mgmt_master_model.sv */
// management master model on the plain register port
// assumes ref_clk from the bench; tasks are called hierarchically
`timescale 1ns/100ps
module mgmt_master_model (
  input  wire logic        ref_clk,
  output logic      [4:0]  reg_addr,
  output logic      [15:0] reg_wdata,
  output logic             reg_write,
  output logic             reg_read,
  input  wire logic [15:0] reg_rdata
);
  // ----------
  // bus cycles, control speed and duplex bits not interpreted
  // ----------
  initial begin
    reg_addr = 5'h00;
    reg_wdata = 16'h0000;
    reg_write = 1'b0;
    reg_read = 1'b0;
  end
  task automatic wr(input logic [4:0] a, input logic [15:0] v);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_write <= 1'b1;
    @(posedge ref_clk);
    reg_write <= 1'b0;
  endtask : wr
  task automatic rd(input logic [4:0] a, output logic [15:0] v);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge ref_clk);
    reg_read <= 1'b0;
    @(posedge ref_clk);
    v = reg_rdata;
  endtask : rd
endmodule : mgmt_master_model

/* File: tb/tb_top.sv */
// self-checking bench for the emulated phy register bank
// assumes the design, the master model and the bound checker
`timescale 1ns/100ps
`include "vphy_params.svh"
module tb_top;
  // ----------
  // design, master, scenarios
  // ----------
  localparam int RC = 8;
  logic        ref_clk, rst_n, mii, pin, pol, spd, mac, rld, wr, rd, o_spd, o_fd, o_tx, o_rx;
  logic [4:0]  addr;
  logic [15:0] wd, rdata, d;
  int          miscompares, samples_checked;
  emulated_phy_autoneg_regs #(.RESET_CYCLES(RC)) u_emulated_phy_autoneg_regs (.ref_clk(ref_clk), .rst_n(rst_n),
    .reg_addr(addr), .reg_wdata(wd), .reg_write(wr), .reg_read(rd), .mii_mgmt_access(mii), .reg_rdata(rdata),
    .duplex_pin(pin), .duplex_pol_strap(pol), .speed_strap(spd), .mac_mode(mac), .eeprom_reload(rld),
    .port_speed_100(o_spd), .port_full_duplex(o_fd), .port_tx_pause(o_tx), .port_rx_pause(o_rx));
  mgmt_master_model u_mgmt_master_model (.ref_clk(ref_clk), .reg_addr(addr), .reg_wdata(wd), .reg_write(wr),
    .reg_read(rd), .reg_rdata(rdata));
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : cyc
  task automatic check(input string n, input logic [15:0] s, input logic [15:0] e);
    samples_checked++;
    if (s !== e) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask : check
  task automatic rc(input logic [4:0] a, input logic [15:0] e);
    u_mgmt_master_model.rd(a, d);
    check($sformatf("register %h", a), d, e);
  endtask : rc
  task automatic wrt(input logic [4:0] a, input logic [15:0] v, input int n);
    u_mgmt_master_model.wr(a, v);
    cyc(n);
  endtask : wrt
  task automatic outs(input logic [3:0] e);
    check("speed duplex tx rx", {12'h000, o_spd, o_fd, o_tx, o_rx}, {12'h000, e});
  endtask : outs
  task automatic final_report;
    if (miscompares == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : final_report
  task automatic neg(input logic [2:0] s, input logic [15:0] ad, lp, ex, input logic [3:0] ob, o);
    {pin, pol, spd} <= s;
    cyc(6);
    wrt(`OFS_ADV, ad, 6);
    outs(ob);
    wrt(`OFS_BASIC_CTRL, 16'h3300, 8);
    rc(`OFS_EXPANSION, ex);
    rc(`OFS_PARTNER, lp);
    outs(o);
    pin <= ~s[2];
    cyc(8);
    outs(o);
  endtask : neg
  task automatic t_priority;
    neg(3'b001, 16'h05e1, 16'h05e1, 16'h0003, 4'hf, 4'hf);
    neg(3'b101, 16'h05e1, 16'h04a1, 16'h0003, 4'hf, 4'hb);
    neg(3'b000, 16'h05e1, 16'h0461, 16'h0003, 4'hb, 4'h7);
    neg(3'b100, 16'h05e1, 16'h0421, 16'h0003, 4'h7, 4'h3);
    neg(3'b001, 16'h09e1, 16'h09e1, 16'h0003, 4'h3, 4'he);
    neg(3'b001, 16'h01e1, 16'h01e1, 16'h0003, 4'he, 4'hc);
    neg(3'b100, 16'h0041, 16'h0021, 16'h0002, 4'hc, 4'h0);
    neg(3'b101, 16'h0041, 16'h0081, 16'h0002, 4'h0, 4'h8);
  endtask : t_priority
  task automatic t_forced;
    wrt(`OFS_BASIC_CTRL, 16'h0000, 8);
    outs(4'h0);
    wrt(`OFS_MANUAL_FC, 16'h0004, 4);
    outs(4'h2);
    rc(`OFS_MANUAL_FC, 16'h0008);
    rc(`OFS_ADV, 16'h0041);
    wrt(`OFS_BASIC_CTRL, 16'h2100, 8);
    outs(4'he);
  endtask : t_forced
  task automatic t_mac;
    mac <= 1'b1;
    mii <= 1'b1;
    pin <= 1'b1;
    rc(`OFS_BASIC_CTRL, 16'hffff);
    wrt(`OFS_BASIC_CTRL, 16'h3100, 0);
    mii <= 1'b0;
    rc(`OFS_BASIC_CTRL, 16'h2100);
    check("full duplex", {15'h0000, o_fd}, 16'h0001);
    wrt(`OFS_BASIC_CTRL, 16'h1000, 10);
    check("full duplex", {15'h0000, o_fd}, 16'h0000);
    pin <= 1'b0;
    cyc(10);
    check("full duplex", {15'h0000, o_fd}, 16'h0001);
    mac <= 1'b0;
  endtask : t_mac
  task automatic t_resets;
    wrt(`OFS_CHIP_RESET_CONTROL_REG, 16'h0008, 0);
    rc(`OFS_CHIP_RESET_CONTROL_REG, 16'h0008);
    cyc(RC + 4);
    rc(`OFS_CHIP_RESET_CONTROL_REG, 16'h0000);
    rc(`OFS_BASIC_CTRL, 16'h3100);
    rc(`OFS_EXPANSION, 16'h0003);
    wrt(`OFS_BASIC_CTRL, 16'hb100, 8);
    rc(`OFS_BASIC_CTRL, 16'h3100);
    rc(`OFS_EXPANSION, 16'h0003);
    wrt(`OFS_CHIP_RESET_CONTROL_REG, 16'h0400, RC + 4);
    rc(`OFS_EXPANSION, 16'h0003);
    rld <= 1'b1;
    cyc(1);
    rld <= 1'b0;
    cyc(8);
    rc(`OFS_EXPANSION, 16'h0003);
    outs(4'hf);
  endtask : t_resets
  initial begin
    {rst_n, mii, pin, pol, spd, mac, rld} = 7'b0000100;
    miscompares = 0;
    samples_checked = 0;
    cyc(3);
    rst_n <= 1'b1;
    cyc(8);
    rc(`OFS_ADV, `RST_ADV);
    rc(`OFS_BASIC_STAT, `STAT_CONST | 16'h0020);
    rc(`OFS_EXPANSION, 16'h0003);
    rc(`OFS_PARTNER, 16'h05e1);
    rc(5'h1f, 16'h0000);
    outs(4'hf);
    t_priority();
    t_forced();
    t_mac();
    t_resets();
    final_report();
  end
  initial begin
    #1000000;
    miscompares++;
    final_report();
  end
endmodule : tb_top
